// File: test_timer8_cc_channels.sv
// bench for the two capture/compare channels
// assumes the pin model drives counter and pins
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %0t: %h not %h", $time, g, e); end end
module test_timer8_cc_channels import timer8_cc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic runReq = 1'b0;
   logic upDownMode = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [1:0] pulseReq = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [7:0] timerCount;
   logic [1:0] chanIn, chanOut, chanEvent;
   logic hreadyout, hresp, timerRun, countDown, irq;
   wire hready = hreadyout;
   int n_fail = 0;
   int num_checks = 0;
   timer8_cc_channels uut (.*);
   timer8_cc_pins pins (.*);
   always #12.5 clk_sys = !clk_sys;
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic rdy;
      for (int k = 0; k < 9; k++) begin
         @(posedge clk_sys);
         if (hready === 1'b1) return;
      end
      n_fail++;
      close_out;
   endtask
   // address phase, then data phase; read data taken at its closing edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
      output logic [7:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      rdy;
      r = hrdata[7:0];
      `CHK(hresp, 1'b0)
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdChk(input logic [31:0] a, input logic [7:0] e);
      logic [7:0] r;
      bus(1'b0, a, 8'h00, r);
      `CHK(r, e)
   endtask
   // waits for a fresh visit of a count, then judges one output unless ch is negative
   task automatic at(input logic [7:0] v, input logic dn, input int ch, input logic e);
      int k;
      for (k = 0; k < 6000 && !(k > 20 && timerCount === v && countDown === dn); k++)
         @(posedge clk_sys);
      if (k == 6000) begin
         n_fail++;
         close_out;
      end
      if (ch >= 0) `CHK(chanOut[ch], e)
   endtask
   task automatic regs;
      rdChk(32'h330, 8'h40);
      rdChk(32'h334, 8'h00);
      rdChk(32'h338, 8'h40);
      rdChk(32'h348, 8'h00);
      wr(32'h330, 8'hFF);
      rdChk(32'h330, 8'h7F);
      wr(32'h33C, 8'hA5);
      rdChk(32'h33C, 8'hA5);
   endtask
   task automatic cmp1;
      logic [2:0] code [5] = '{3'h0, 3'h7, 3'h2, 3'h2, 3'h1};
      logic want [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      wr(32'h33C, 8'h0A);
      foreach (code[i]) begin
         wr(32'h338, {2'b01, code[i], 3'b100});
         at(8'h0B, 1'b0, 1, want[i]);
      end
      `CHK(irq, 1'b1)
      wr(32'h340, 8'h03);
      repeat (2) @(posedge clk_sys);
      `CHK(irq, 1'b0)
   endtask
   task automatic match0;
      wr(32'h334, 8'h32);
      wr(32'h330, 8'h44);
      at(8'h01, 1'b0, -1, 1'b0);
      at(8'h33, 1'b0, 0, 1'b1);
      wr(32'h330, 8'h54);
      wr(32'h334, 8'h64);
      at(8'h65, 1'b0, 0, 1'b1);
      at(8'h65, 1'b0, 0, 1'b0);
      wr(32'h330, 8'h6C);
      at(8'h65, 1'b0, 0, 1'b1);
      at(8'h00, 1'b0, 0, 1'b0);
      wr(32'h330, 8'h74);
      at(8'h65, 1'b0, 0, 1'b0);
      at(8'h01, 1'b0, 0, 1'b1);
      wr(32'h33C, 8'h96);
      wr(32'h338, 8'h6C);
      at(8'h97, 1'b0, 1, 1'b1);
      at(8'h65, 1'b0, 1, 1'b0);
   endtask
   task automatic upDown;
      wr(32'h33C, 8'h14);
      wr(32'h338, 8'h5C);
      at(8'h15, 1'b0, 1, 1'b1);
      at(8'h13, 1'b1, 1, 1'b0);
      wr(32'h338, 8'h64);
      at(8'h15, 1'b0, 1, 1'b0);
      at(8'h13, 1'b1, 1, 1'b1);
   endtask
   task automatic capture;
      int want [4] = '{0, 1, 1, 2};
      int n, k;
      logic [7:0] c;
      wr(32'h338, 8'h40);
      for (int m = 0; m < 4; m++) begin
         wr(32'h330, {1'b0, m != 2, 4'h0, 2'(m)});
         wr(32'h340, 8'h03);
         c = timerCount;
         for (k = 0; k < 30 && timerCount === c; k++) @(posedge clk_sys);
         c = timerCount;
         pulseReq[0] <= 1'b1;
         @(posedge clk_sys);
         pulseReq[0] <= 1'b0;
         n = 0;
         repeat (12) begin
            @(posedge clk_sys);
            n += chanEvent[0];
         end
         `CHK(n, want[m])
         if (m > 0) rdChk(32'h334, c);
         `CHK(irq, m % 2 == 1)
         rdChk(32'h340, {7'h0, m > 0});
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      regs;
      runReq <= 1'b1;
      cmp1;
      match0;
      upDownMode <= 1'b1;
      upDown;
      capture;
      close_out;
   end
endmodule

// File: timer8_cc_asserts.sv
// port checker for the two capture/compare channels
// assumes one clock domain and the async low reset
module timer8_cc_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [7:0] timerCount,
   input wire logic timerRun,
   input wire logic [1:0] chanOut,
   input wire logic [1:0] chanEvent,
   input wire logic irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [7:0] lastCnt_ff;
   logic lastRun_ff;
   logic wrData_ff;
   logic rdCtl_ff;
   wire take = hsel && hready && htrans[1];
   wire step = (timerCount != lastCnt_ff) || (timerRun && !lastRun_ff);
   // counter history and bus phases; only writes may drop the request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lastCnt_ff <= 8'h00;
         lastRun_ff <= 1'b0;
         wrData_ff <= 1'b0;
         rdCtl_ff <= 1'b0;
      end else begin
         lastCnt_ff <= timerCount;
         lastRun_ff <= timerRun;
         wrData_ff <= take && hwrite;
         rdCtl_ff <= take && !hwrite && (haddr == 32'h330 || haddr == 32'h338);
      end
   end
   sequence stopped;
      (!timerRun && $stable(timerCount)) [*6];
   endsequence
   out_on_step_a: assert property ($changed(chanOut) |-> $past(step))
      else $error("output moved off a step");
   irq_fall_a: assert property ($fell(irq) |-> $past(wrData_ff) || $past(wrData_ff, 2))
      else $error("irq fell without a write");
   event0_pulse_a: assert property (chanEvent[0] |=> !chanEvent[0])
      else $error("event 0 too long");
   event1_pulse_a: assert property (chanEvent[1] |=> !chanEvent[1])
      else $error("event 1 too long");
   stop_quiet_a: assert property (stopped |=> chanEvent == 2'h0)
      else $error("event while stopped");
   top_bit_a: assert property (rdCtl_ff |-> !hrdata[7])
      else $error("unused bit read one");
   byte_wide_a: assert property ($past(take && !hwrite) |-> hrdata[31:8] == 24'h0)
      else $error("read wider than a byte");
   irq_rise_a: assert property ($rose(irq) |-> $past(chanEvent != 2'h0, 1)
      || chanEvent != 2'h0 || $past(wrData_ff) || $past(wrData_ff, 2))
      else $error("irq rose without cause");
endmodule
bind timer8_cc_channels timer8_cc_chk chk (.*);

// File: timer8_cc_channels.sv
// timer8_cc_channels.sv: two capture/compare channels of an 8-bit timer with an
// AHB-Lite register slave and one level interrupt. assumes the counter, its run
// flag, direction and up/down mode come from the timer core on the same clock.
`include "timer8_cc_params.svh"
module timer8_cc_channels
   import timer8_cc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] timerCount,
   input wire logic timerRun,
   input wire logic countDown,
   input wire logic upDownMode,
   input wire logic [1:0] chanIn,
   output logic [1:0] chanOut,
   output logic [1:0] chanEvent,
   output logic irq
);
   // bus slave state
   bus_state_type busState_ff;
   logic wrPend_ff;
   logic [7:0] wrIdx_ff;
   logic [31:0] rdData_ff;
   logic [6:0] ctrl0_ff;
   logic [6:0] ctrl1_ff;
   logic [7:0] val0_ff;
   logic [7:0] val1_ff;
   logic [7:0] active0_ff;
   logic [1:0] status_ff;
   logic [1:0] irqEn_ff;
   logic [1:0] out_ff;
   logic [1:0] event_ff;
   logic irq_ff;
   logic [1:0] sync1_ff;
   logic [1:0] sync2_ff;
   logic [1:0] sync3_ff;
   logic [1:0] stable_ff;
   logic [7:0] prevCount_ff;
   logic prevRun_ff;
   logic readyOut_ff;
   logic respErr_ff;
   bus_state_type nxt_busState;

   // the slave never stretches a transfer: hreadyout stays high, so an address
   // phase is taken on its first edge and its data phase ends on the next one
   // limitation: hsize is ignored, every access is treated as a whole word

   // address phase decode; byte address is four times the printed index
   wire logic addrPhase = hsel & hready & htrans[1];
   wire logic [7:0] addrIdx = haddr[9:2];
   wire logic inRange = (haddr[31:10] == 22'h000000);
   wire logic wrAccept = addrPhase & hwrite;
   wire logic rdAccept = addrPhase & ~hwrite;

   // bus phase tracker; a data phase follows every accepted address phase
   always_comb begin
      nxt_busState = BUS_IDLE;
      case (busState_ff)
         BUS_IDLE: nxt_busState = addrPhase ? BUS_DATA : BUS_IDLE;
         BUS_DATA: nxt_busState = addrPhase ? BUS_DATA : BUS_IDLE;
         default: nxt_busState = BUS_IDLE;
      endcase
   end

   // write strobes fire only inside a tracked data phase, so a stray pending
   // flag can never write a register outside a transfer
   wire logic dataPhase = (busState_ff == BUS_DATA);
   wire logic wrStb = wrPend_ff & dataPhase;
   wire logic wrCtrl0 = wrStb & (wrIdx_ff == `CC_IDX_CTRL0);
   wire logic wrVal0 = wrStb & (wrIdx_ff == `CC_IDX_VAL0);
   wire logic wrCtrl1 = wrStb & (wrIdx_ff == `CC_IDX_CTRL1);
   wire logic wrVal1 = wrStb & (wrIdx_ff == `CC_IDX_VAL1);
   wire logic wrStatus = wrStb & (wrIdx_ff == `CC_IDX_STATUS);
   wire logic wrIrqEn = wrStb & (wrIdx_ff == `CC_IDX_IRQEN);

   wire logic [7:0] rdCtrl0 = {1'b0, ctrl0_ff};
   wire logic [7:0] rdCtrl1 = {1'b0, ctrl1_ff};
   // register map in word steps: control 0, value 0, control 1, value 1,
   // then the event status (write one to clear) and the request enable
   // unmapped offsets read zero and still answer OKAY
   wire logic [7:0] rdByte =
      !inRange ? 8'h00 :
      (addrIdx == `CC_IDX_CTRL0) ? rdCtrl0 :
      (addrIdx == `CC_IDX_VAL0) ? val0_ff :
      (addrIdx == `CC_IDX_CTRL1) ? rdCtrl1 :
      (addrIdx == `CC_IDX_VAL1) ? val1_ff :
      (addrIdx == `CC_IDX_STATUS) ? {6'h00, status_ff} :
      (addrIdx == `CC_IDX_IRQEN) ? {6'h00, irqEn_ff} : 8'h00;

   // the control byte is kept as seven flops; bit 7 has no storage at all,
   // so reading it as zero needs no extra masking on the write path
   // control fields
   wire match_action_type act0 = match_action_type'(ctrl0_ff[5:3]);
   wire match_action_type act1 = match_action_type'(ctrl1_ff[5:3]);
   wire edge_trigger_type edgeSel0 = edge_trigger_type'(ctrl0_ff[1:0]);
   wire edge_trigger_type edgeSel1 = edge_trigger_type'(ctrl1_ff[1:0]);
   wire logic cmpMode0 = ctrl0_ff[`CC_BIT_MODE];
   wire logic cmpMode1 = ctrl1_ff[`CC_BIT_MODE];

   // a counter step is seen only when the count moves or the timer just started,
   // so a stalled counter does not match again on every clock
   // trade-off: a counter reloaded with the value it already holds gives no step;
   // the timer core never does that while running
   wire logic cntStep = timerRun & ((timerCount != prevCount_ff) | ~prevRun_ff);
   wire logic atZero = cntStep & (timerCount == `CC_CNT_ZERO);
   wire logic atTop = cntStep & (timerCount == `CC_CNT_TOP);
   wire logic match0 = cntStep & cmpMode0 & (timerCount == active0_ff);
   wire logic match1 = cntStep & cmpMode1 & (timerCount == val1_ff);
   wire logic hitVal0 = cntStep & (timerCount == active0_ff);
   wire logic matchUp0 = match0 & ~(upDownMode & countDown);
   wire logic matchDn0 = match0 & upDownMode & countDown;
   wire logic matchUp1 = match1 & ~(upDownMode & countDown);
   wire logic matchDn1 = match1 & upDownMode & countDown;
   // in up/down counting the down match replaces the zero action
   wire logic zeroAct = atZero & ~upDownMode;

   // change counts once stages two and three agree
   // hazard: a pin level held for less than two clocks may be filtered out;
   // the far side must keep each level for at least two clock periods
   wire logic [1:0] pinAgree = ~(sync2_ff ^ sync3_ff);
   wire logic [1:0] nxt_stable = (pinAgree & sync3_ff) | (~pinAgree & stable_ff);
   wire logic [1:0] rise = nxt_stable & ~stable_ff;
   wire logic [1:0] fall = ~nxt_stable & stable_ff;

   wire logic edgeHit0 = (edgeSel0[0] & rise[0]) | (edgeSel0[1] & fall[0]);
   wire logic edgeHit1 = (edgeSel1[0] & rise[1]) | (edgeSel1[1] & fall[1]);
   // capture only while the timer runs
   wire logic cap0 = timerRun & ~cmpMode0 & edgeHit0;
   wire logic cap1 = timerRun & ~cmpMode1 & edgeHit1;

   // capture or compare is the channel event
   wire logic [1:0] chEvt = {cap1 | match1, cap0 | match0};

   // one shared decoder serves both channels, so their outputs cannot drift
   // apart in behaviour; only the source of the second edge differs
   // output action for both channels
   function automatic logic nextOut(
      input match_action_type act, input logic cur, input logic mUp, input logic mDn,
      input logic zero, input logic altClr);
      logic m;
      m = mUp | mDn;
      case (act)
         ACT_SET: nextOut = m ? 1'b1 : cur;
         ACT_CLR: nextOut = m ? 1'b0 : cur;
         ACT_TGL: nextOut = m ? ~cur : cur;
         ACT_PWM_SET: nextOut = mUp ? 1'b1 : ((mDn | zero) ? 1'b0 : cur);
         ACT_PWM_CLR: nextOut = mUp ? 1'b0 : ((mDn | zero) ? 1'b1 : cur);
         ACT_SET_ALT: nextOut = m ? 1'b1 : (altClr ? 1'b0 : cur);
         ACT_CLR_ALT: nextOut = m ? 1'b0 : (altClr ? 1'b1 : cur);
         default: nextOut = cur;
      endcase
   endfunction

   // clear at top, set at zero for channel 0
   wire logic alt0 = (act0 == ACT_SET_ALT) ? atTop : atZero;
   // channel 1 second edge on the channel 0 value
   wire logic alt1 = hitVal0;
   wire logic nxtOut0 = cmpMode0 ? nextOut(act0, out_ff[0], matchUp0, matchDn0, zeroAct, alt0)
                                 : out_ff[0];
   wire logic nxtOut1 = cmpMode1 ? nextOut(act1, out_ff[1], matchUp1, matchDn1, zeroAct, alt1)
                                 : out_ff[1];

   // sticky status: set wins over write-one-to-clear
   // an event landing in the same cycle as a clear is kept, so none is lost
   wire logic [1:0] nxt_status = chEvt | (status_ff & ~(wrStatus ? hwdata[1:0] : 2'b00));
   // masked request, also gated by the channel mask bit
   wire logic [1:0] chanMask = {ctrl1_ff[`CC_BIT_IM], ctrl0_ff[`CC_BIT_IM]};
   wire logic nxt_irq = |(nxt_status & irqEn_ff & chanMask);

   // bus handshake: zero wait states, write data lands one cycle after address
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busState_ff <= BUS_IDLE;
         wrPend_ff <= 1'b0;
         wrIdx_ff <= 8'h00;
         rdData_ff <= 32'h00000000;
      end else begin
         busState_ff <= nxt_busState;
         wrPend_ff <= wrAccept & inRange;
         wrIdx_ff <= addrIdx;
         if (rdAccept) rdData_ff <= {24'h000000, rdByte};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl0_ff <= 7'(`CC_CTRL_RESET);
         ctrl1_ff <= 7'(`CC_CTRL_RESET);
         irqEn_ff <= 2'h3;
      end else begin
         if (wrCtrl0) ctrl0_ff <= hwdata[6:0];
         if (wrCtrl1) ctrl1_ff <= hwdata[6:0];
         if (wrIrqEn) irqEn_ff <= hwdata[1:0];
      end
   end

   // value registers; a capture wins over a same-cycle write
   // limitation: the losing write is dropped, software re-reads to see which won
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         val0_ff <= `CC_VAL_RESET;
         val1_ff <= `CC_VAL_RESET;
      end else begin
         if (cap0) val0_ff <= timerCount;
         else if (wrVal0) val0_ff <= hwdata[7:0];
         if (cap1) val1_ff <= timerCount;
         else if (wrVal1) val1_ff <= hwdata[7:0];
      end
   end

   // channel 0 compare value reloads only at zero while the timer runs
   // the shadow also follows the value while the timer is stopped, so a compare
   // set up before start is live on the very first count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) active0_ff <= `CC_VAL_RESET;
      else if (atZero | ~timerRun) active0_ff <= val0_ff;
   end

   // three-stage input synchroniser; first stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_ff <= 2'b00;
         sync2_ff <= 2'b00;
         sync3_ff <= 2'b00;
         stable_ff <= 2'b00;
      end else begin
         sync1_ff <= chanIn;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         stable_ff <= nxt_stable;
      end
   end

   // outputs, events, status and interrupt
   // the previous count and run flag are kept here to find counter steps
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= 2'b00;
         event_ff <= 2'b00;
         status_ff <= 2'b00;
         irq_ff <= 1'b0;
         prevCount_ff <= 8'h00;
         prevRun_ff <= 1'b0;
      end else begin
         out_ff <= {nxtOut1, nxtOut0};
         event_ff <= chEvt;
         status_ff <= nxt_status;
         irq_ff <= nxt_irq;
         prevCount_ff <= timerCount;
         prevRun_ff <= timerRun;
      end
   end

   // handshake flags come from flops so every port is registered;
   // no wait states are ever inserted and every response is OKAY
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         readyOut_ff <= 1'b1;
         respErr_ff <= 1'b0;
      end else begin
         readyOut_ff <= 1'b1;
         respErr_ff <= 1'b0;
      end
   end

   // port drivers
   assign hrdata = rdData_ff;
   assign hreadyout = readyOut_ff;
   assign hresp = respErr_ff;
   assign chanOut = out_ff;
   assign chanEvent = event_ff;
   assign irq = irq_ff;
endmodule

// File: timer8_cc_params.svh
// timer8_cc_params.svh: offsets, field positions, reset values and timing counts
// of the two capture/compare channels; assumes a 32-bit AHB-Lite register bus.
// Functional notes
// - control bit 6 is the channel interrupt mask, reset 1, 1 enables the request.
// - control bits 5:3 pick the output action taken on a match of the counter with the value.
// - action 000 sets, 001 clears and 010 toggles the output on a match.
// - action 011 sets on an up match and clears at zero, or clears on a down match in up/down.
// - action 100 clears on an up match and sets at zero, or sets on a down match in up/down.
// - on channel 0, action 101 sets on a match and clears when the counter reaches 0xFF.
// - on channel 0, action 110 clears on a match and sets when the counter reaches 0x00.
// - on channel 1, 101 sets on its match and clears on the channel 0 value; 110 does the reverse.
// - control bit 2 selects capture (0, the reset value) or compare (1).
// - control bits 1:0 pick the capture edge: none, rising, falling or both.
// - each channel has an 8-bit read/write value register that resets to 0x00.
// - in capture mode a running timer copies the counter into the value on the chosen edge.
// - a capture or compare sets the channel event flag; a request needs the mask set.
// - while the timer runs, channel 0 value writes reach the compare only at counter 0x00; channel 1 writes at once.
// - channel inputs are synchronised; the source holds each level for at least two clock periods.
`ifndef TIMER8_CC_PARAMS_SVH
`define TIMER8_CC_PARAMS_SVH
`define CC_IDX_CTRL0 8'hCC
`define CC_IDX_VAL0 8'hCD
`define CC_IDX_CTRL1 8'hCE
`define CC_IDX_VAL1 8'hCF
`define CC_IDX_STATUS 8'hD0
`define CC_IDX_IRQEN 8'hD1
`define CC_BIT_IM 6
`define CC_BIT_MODE 2
`define CC_CTRL_RESET 8'h40
`define CC_CTRL_WMASK 8'h7F
`define CC_VAL_RESET 8'h00
`define CC_CNT_TOP 8'hFF
`define CC_CNT_ZERO 8'h00
`define CC_SYNC_STAGES 3
`endif

// File: timer8_cc_pins.sv
// counter and pin source standing in for the timer core and pins
// assumes the bench asks for run, up/down and pin pulses
module timer8_cc_pins #(parameter int DIV = 10) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic runReq,
   input wire logic upDownMode,
   input wire logic [1:0] pulseReq,
   output logic [7:0] timerCount,
   output logic timerRun,
   output logic countDown,
   output logic [1:0] chanIn
);
   logic [3:0] div_ff;
   logic [1:0] held_ff;
   wire tick = div_ff == 4'(DIV - 1);
   assign chanIn = pulseReq | held_ff;
   // slow steps keep the count steady through the input synchroniser
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 4'h0;
         held_ff <= 2'h0;
         timerRun <= 1'b0;
         timerCount <= 8'h00;
         countDown <= 1'b0;
      end else begin
         div_ff <= tick ? 4'h0 : div_ff + 4'h1;
         held_ff <= pulseReq;
         timerRun <= runReq;
         if (tick && runReq) begin
            timerCount <= countDown ? timerCount - 8'h01 : timerCount + 8'h01;
            if (upDownMode && timerCount == (countDown ? 8'h01 : 8'hFE)) begin
               countDown <= !countDown;
            end
         end
      end
   end
endmodule

// File: timer8_cc_pkg.sv
// timer8_cc_pkg.sv: types shared by the capture/compare channel block.
// assumes the params header is included by the design file.
package timer8_cc_pkg;
   typedef enum logic [2:0] {
      ACT_SET = 3'h0, ACT_CLR = 3'h1, ACT_TGL = 3'h2, ACT_PWM_SET = 3'h3,
      ACT_PWM_CLR = 3'h4, ACT_SET_ALT = 3'h5, ACT_CLR_ALT = 3'h6, ACT_NONE = 3'h7
   } match_action_type;
   typedef enum logic [1:0] {
      EDGE_OFF = 2'h0, EDGE_RISE = 2'h1, EDGE_FALL = 2'h2, EDGE_BOTH = 2'h3
   } edge_trigger_type;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01, BUS_DATA = 2'b10
   } bus_state_type;
endpackage
